// ---- gpp_pkg.sv ----
/*
  Shared constants and types for the gaussian pulse pair generator: timing
  ranges, register map, control fields, shape table and the sample carrier.
  Assumes a 100 MHz clock; every timing field counts 0.05 us steps.
*/
package gpp_pkg;

  localparam int CLK_MHZ = 100;
  localparam int STEP_NS = 50;
  localparam int STEP_CYC = STEP_NS * CLK_MHZ / 1000;

  localparam int TW = 22;
  localparam int CW = 25;

  // Ranges in ns as specified, and in 0.05 us steps.
  localparam int WIDTH_MIN_NS = 2500;
  localparam int WIDTH_MAX_NS = 8000;
  localparam int RISE_MIN_NS = 800;
  localparam int FALL_MIN_NS = 1500;
  localparam int EDGE_MAX_NS = 5750;
  localparam int SPACE_MIN_NS = 9000;
  localparam int SPACE_MAX_NS = 45000;
  localparam int PERIOD_MIN_NS = 166650;
  localparam int PERIOD_MAX_NS = 100000000;
  localparam logic [TW-1:0] WIDTH_MIN = TW'(WIDTH_MIN_NS / STEP_NS);
  localparam logic [TW-1:0] WIDTH_MAX = TW'(WIDTH_MAX_NS / STEP_NS);
  localparam logic [TW-1:0] RISE_MIN = TW'(RISE_MIN_NS / STEP_NS);
  localparam logic [TW-1:0] FALL_MIN = TW'(FALL_MIN_NS / STEP_NS);
  localparam logic [TW-1:0] EDGE_MAX = TW'(EDGE_MAX_NS / STEP_NS);
  localparam logic [TW-1:0] SPACE_MIN = TW'(SPACE_MIN_NS / STEP_NS);
  localparam logic [TW-1:0] SPACE_MAX_STEPS = TW'(SPACE_MAX_NS / STEP_NS);
  localparam logic [TW-1:0] PERIOD_MIN_STEPS = TW'(PERIOD_MIN_NS / STEP_NS);
  localparam logic [TW-1:0] PERIOD_MAX_STEPS = TW'(PERIOD_MAX_NS / STEP_NS);

  // Marker pulse width, rounded up to whole cycles.
  localparam int MARK_NS = 400;
  localparam int MARK_CYC = (MARK_NS * CLK_MHZ + 999) / 1000;
  localparam logic [5:0] MARK_LOAD = 6'(MARK_CYC);

  // Reset values of the timing and level settings.
  localparam logic [TW-1:0] WIDTH_RST = 22'h00_0046;
  localparam logic [TW-1:0] RISE_RST = 22'h00_0032;
  localparam logic [TW-1:0] FALL_RST = 22'h00_0032;
  localparam logic [TW-1:0] SPACE_RST = 22'h00_00F0;
  localparam logic [TW-1:0] PERIOD_RST = 22'h00_2710;

  // Level in tenths of dBm, two's complement.
  localparam logic signed [11:0] LEVEL_MAX = 12'sh0_064;
  localparam logic signed [11:0] LEVEL_MIN = -12'sh0_44C;
  localparam logic signed [11:0] LEVEL_RST = -12'sh0_44C;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WIDTH = 8'h04;
  localparam logic [7:0] ADDR_RISE = 8'h08;
  localparam logic [7:0] ADDR_FALL = 8'h0C;
  localparam logic [7:0] ADDR_SPACE = 8'h10;
  localparam logic [7:0] ADDR_PERIOD = 8'h14;
  localparam logic [7:0] ADDR_LEVEL = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;

  // Control fields.
  localparam int CTRL_EN = 0;
  localparam int CTRL_EXT = 1;
  localparam int CTRL_DIRECT = 2;
  localparam int CTRL_W = 3;

  // Status fields.
  localparam int ST_BUSY = 0;
  localparam int ST_SHAPE_ERR = 1;
  localparam int ST_FULL = 2;
  localparam int ST_LVL_LO = 8;
  localparam int ST_CNT_LO = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Rising half of the quantised gaussian, index 0 at minimum, 15 at peak.
  // The 10 % point sits at entry 4, 50 % at entry 8 and 90 % at entry 12.
  localparam int LUT_N = 16;
  localparam int LUT_SPAN = 8;
  localparam int LUT_HALF = 7;
  localparam logic [3:0] LUT_TOP = 4'hF;
  localparam logic [3:0] LUT_BOT = 4'h0;
  localparam logic [LUT_N-1:0][7:0] GAUSS_LUT = {
    8'hFF, 8'hFA, 8'hF2, 8'hE6, 8'hD2, 8'hBE, 8'hA0, 8'h80,
    8'h60, 8'h3E, 8'h28, 8'h1A, 8'h12, 8'h0A, 8'h04, 8'h01};
  localparam logic [7:0] AMP_PEAK = 8'hFF;
  localparam logic [7:0] AMP_ZERO = 8'h00;
  // Amplitudes below this (26 dB under peak) switch the carrier off.
  localparam logic [7:0] KILL_THRESH = 8'h0D;

  localparam int FIFO_DEPTH = 32;

  typedef struct packed {
    logic kill;
    logic [7:0] amp;
  } mod_sample_t;

  typedef enum {S_IDLE, S_RISE, S_TOP, S_FALL, S_GAP, S_WAIT} gen_state_t;

endpackage : gpp_pkg

// ---- gpp_fifo.sv ----
/*
  Synchronous FIFO with valid/ready on both sides and a fill count.
  Assumes one clock and a synchronous active-low reset; DEPTH a power of two.
*/
`timescale 1ns/1ps
module gpp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
)(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Fill side.
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Drain side.
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  // Fill level.
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : gpp_fifo

// ---- gaussian_pulse_pair_generator.sv ----
/*
  Gaussian pulse pair generator with an AXI4-Lite register slave. Shaped
  amplitude samples pass through a FIFO to the RF level modulator.
  Assumes trig_in synchronous to clk and a modulator that pulls samples
  with mod_ready; a stalled modulator freezes the pulse timing.
*/
`timescale 1ns/1ps
module gaussian_pulse_pair_generator import gpp_pkg::*; #(
  parameter logic [TW-1:0] SPACE_MAX = SPACE_MAX_STEPS,
  parameter logic [TW-1:0] PERIOD_MIN = PERIOD_MIN_STEPS,
  parameter logic [TW-1:0] PERIOD_MAX = PERIOD_MAX_STEPS
)(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address and data.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read.
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External trigger and pair marker.
  input wire logic trig_in,
  output logic marker_out,
  // Sample stream to the RF modulator.
  output mod_sample_t mod_sample,
  output logic mod_valid,
  input wire logic mod_ready,
  // Output level as attenuation below +10 dBm in 0.1 dB steps.
  output logic [10:0] level_atten
);

  logic [CTRL_W-1:0] ctrl;
  logic [TW-1:0] width;
  logic [TW-1:0] rise;
  logic [TW-1:0] fall;
  logic [TW-1:0] space;
  logic [TW-1:0] period;
  logic signed [11:0] level;
  logic [15:0] pair_count;

  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_wr;
  logic [31:0] wr_val;

  gen_state_t state;
  logic second;
  logic [3:0] idx;
  logic [CW-1:0] acc;
  logic [CW-1:0] top_cnt;
  logic [CW-1:0] pair_cyc;
  logic [5:0] mark_cnt;
  logic trig_q;
  logic trig_rise;

  logic [CW-1:0] width_cyc;
  logic [CW-1:0] rise_cyc;
  logic [CW-1:0] fall_cyc;
  logic [CW-1:0] space_cyc;
  logic [CW-1:0] period_cyc;
  logic [CW-1:0] edge_cyc;
  logic [CW-1:0] top_cyc;
  logic shape_err;
  logic edge_step;
  logic adv;
  logic gen_en;
  logic start_pair;

  mod_sample_t gen_sample;
  logic [$clog2(FIFO_DEPTH):0] fifo_count;
  logic fifo_in_ready;

  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= ADDR_STATUS);
  endfunction : is_mapped

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    case (a)
      ADDR_CTRL: r = 32'(ctrl);
      ADDR_WIDTH: r = 32'(width);
      ADDR_RISE: r = 32'(rise);
      ADDR_FALL: r = 32'(fall);
      ADDR_SPACE: r = 32'(space);
      ADDR_PERIOD: r = 32'(period);
      ADDR_LEVEL: r = {{20{level[11]}}, level};
      ADDR_STATUS: begin
        r[ST_BUSY] = (state != S_IDLE);
        r[ST_SHAPE_ERR] = shape_err;
        r[ST_FULL] = !fifo_in_ready;
        r[ST_LVL_LO +: 8] = 8'(fifo_count);
        r[ST_CNT_LO +: 16] = pair_count;
      end
      default: r = '0;
    endcase
    return r;
  endfunction : reg_read

  function automatic logic [TW-1:0] clamp(input logic [31:0] v, input logic [TW-1:0] lo,
                                          input logic [TW-1:0] hi);
    if (v < 32'(lo)) begin
      return lo;
    end else if (v > 32'(hi)) begin
      return hi;
    end
    return TW'(v);
  endfunction : clamp

  // Register bus: address and data are caught in either order, then written.
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_wr = aw_got && w_got && !s_axi_bvalid;

  always_comb begin
    wr_val = reg_read(aw_addr);
    for (int b = 0; b < 4; b++) begin
      if (w_strb[b]) begin
        wr_val[8*b +: 8] = w_data[8*b +: 8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= reg_read(s_axi_araddr);
      s_axi_rresp <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Settings stay writable in any mode; values are held inside their ranges.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= '0;
      width <= WIDTH_RST;
      rise <= RISE_RST;
      fall <= FALL_RST;
      space <= SPACE_RST;
      period <= PERIOD_RST;
      level <= LEVEL_RST;
    end else if (do_wr) begin
      case (aw_addr)
        ADDR_CTRL: ctrl <= wr_val[CTRL_W-1:0];
        ADDR_WIDTH: width <= clamp(wr_val, WIDTH_MIN, WIDTH_MAX);
        ADDR_RISE: rise <= clamp(wr_val, RISE_MIN, EDGE_MAX);
        ADDR_FALL: fall <= clamp(wr_val, FALL_MIN, EDGE_MAX);
        ADDR_SPACE: space <= clamp(wr_val, SPACE_MIN, SPACE_MAX);
        ADDR_PERIOD: period <= clamp(wr_val, PERIOD_MIN, PERIOD_MAX);
        ADDR_LEVEL: begin
          if ($signed(wr_val) > 32'(LEVEL_MAX)) begin
            level <= LEVEL_MAX;
          end else if ($signed(wr_val) < 32'(LEVEL_MIN)) begin
            level <= LEVEL_MIN;
          end else begin
            level <= wr_val[11:0];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      level_atten <= '0;
    end else begin
      level_atten <= 11'(LEVEL_MAX - level);
    end
  end

  // Step settings to cycle counts.
  assign width_cyc = CW'(width * STEP_CYC);
  assign rise_cyc = CW'(rise * STEP_CYC);
  assign fall_cyc = CW'(fall * STEP_CYC);
  assign space_cyc = CW'(space * STEP_CYC);
  assign period_cyc = CW'(period * STEP_CYC);

  // Entries 8 to 15 last one edge time on each side, so the top is width less both edges.
  always_comb begin
    int raw;
    raw = int'(width_cyc) - int'(rise_cyc) - int'(fall_cyc);
    shape_err = (raw < 0);
    top_cyc = shape_err ? '0 : CW'(raw);
  end

  // Table entries 4 to 12 cover 10 to 90 %, so each entry lasts edge/8.
  assign edge_cyc = (state == S_FALL) ? fall_cyc : rise_cyc;
  assign edge_step = (acc + CW'(LUT_SPAN) >= edge_cyc);

  assign gen_en = ctrl[CTRL_EN] && !ctrl[CTRL_DIRECT];
  assign adv = fifo_in_ready;
  assign trig_rise = trig_in && !trig_q;
  assign start_pair = gen_en && (ctrl[CTRL_EXT] ? trig_rise : 1'b1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig_in;
    end
  end

  // Pulse sequencer; timing freezes while the FIFO cannot take a sample.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      second <= 1'b0;
      idx <= LUT_BOT;
      acc <= '0;
      top_cnt <= '0;
      pair_cyc <= '0;
    end else if (!gen_en) begin
      state <= S_IDLE;
      idx <= LUT_BOT;
    end else begin
      case (state)
        S_IDLE: begin
          if (start_pair && adv) begin
            state <= S_RISE;
            second <= 1'b0;
            idx <= LUT_BOT;
            acc <= '0;
            pair_cyc <= '0;
          end
        end
        S_RISE: begin
          if (adv) begin
            pair_cyc <= pair_cyc + 1'b1;
            if (edge_step) begin
              acc <= acc + CW'(LUT_SPAN) - edge_cyc;
              if (idx == LUT_TOP) begin
                state <= S_TOP;
                top_cnt <= '0;
              end else begin
                idx <= idx + 1'b1;
              end
            end else begin
              acc <= acc + CW'(LUT_SPAN);
            end
          end
        end
        S_TOP: begin
          if (adv) begin
            pair_cyc <= pair_cyc + 1'b1;
            top_cnt <= top_cnt + 1'b1;
            if (top_cnt + 1'b1 >= top_cyc) begin
              state <= S_FALL;
              acc <= '0;
            end
          end
        end
        S_FALL: begin
          if (adv) begin
            pair_cyc <= pair_cyc + 1'b1;
            if (edge_step) begin
              acc <= acc + CW'(LUT_SPAN) - edge_cyc;
              if (idx == LUT_BOT) begin
                state <= second ? S_WAIT : S_GAP;
              end else begin
                idx <= idx - 1'b1;
              end
            end else begin
              acc <= acc + CW'(LUT_SPAN);
            end
          end
        end
        S_GAP: begin
          if (adv) begin
            pair_cyc <= pair_cyc + 1'b1;
            if (pair_cyc + 1'b1 >= space_cyc) begin
              state <= S_RISE;
              second <= 1'b1;
              acc <= '0;
            end
          end
        end
        S_WAIT: begin
          if (ctrl[CTRL_EXT]) begin
            state <= S_IDLE;
          end else if (adv) begin
            pair_cyc <= pair_cyc + 1'b1;
            if (pair_cyc + 1'b1 >= period_cyc) begin
              state <= S_RISE;
              second <= 1'b0;
              acc <= '0;
              pair_cyc <= '0;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Marker fires as the first pulse takes its first step off the minimum.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mark_cnt <= '0;
      marker_out <= 1'b0;
      pair_count <= '0;
    end else if (gen_en && adv && state == S_RISE && !second && idx == LUT_BOT
                 && edge_step) begin
      mark_cnt <= MARK_LOAD - 1'b1;
      marker_out <= 1'b1;
      pair_count <= pair_count + 1'b1;
    end else if (mark_cnt != '0) begin
      mark_cnt <= mark_cnt - 1'b1;
    end else begin
      marker_out <= 1'b0;
    end
  end

  // Sample for the modulator; the carrier is cut below the linear span.
  always_comb begin
    gen_sample.amp = AMP_ZERO;
    if (ctrl[CTRL_EN] && ctrl[CTRL_DIRECT]) begin
      gen_sample.amp = trig_in ? AMP_PEAK : AMP_ZERO;
    end else if (state == S_RISE || state == S_TOP || state == S_FALL) begin
      gen_sample.amp = GAUSS_LUT[idx];
    end
    gen_sample.kill = (gen_sample.amp < KILL_THRESH);
  end

  gpp_fifo #(
    .WIDTH($bits(mod_sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_data(gen_sample),
    .in_valid(ctrl[CTRL_EN]),
    .in_ready(fifo_in_ready),
    .out_data(mod_sample),
    .out_valid(mod_valid),
    .out_ready(mod_ready),
    .count(fifo_count)
  );

endmodule : gaussian_pulse_pair_generator

// ---- gaussian_pulse_pair_generator_assertions.sv ----
/*
  Port checker for the gaussian pulse pair generator.
  Assumes one clock with a synchronous active-low reset; bound at the foot.
*/
`timescale 1ns/1ps
module gpp_checker import gpp_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Marker, stream and level.
  input wire logic marker_out,
  input wire mod_sample_t mod_sample,
  input wire logic mod_valid,
  input wire logic mod_ready,
  input wire logic [10:0] level_atten
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Counts how long the marker has been high so far.
  logic [7:0] mcnt;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mcnt <= 8'h00;
    end else if (marker_out) begin
      mcnt <= mcnt + 8'h01;
    end else begin
      mcnt <= 8'h00;
    end
  end

  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  chk_write_answer: assert property (aw_w_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (ar_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  chk_marker_len: assert property ($fell(marker_out) |-> mcnt == 8'(MARK_CYC))
    else $error("marker too short");
  chk_marker_max: assert property (marker_out |-> mcnt < 8'(MARK_CYC))
    else $error("marker too long");
  chk_kill_flag: assert property (mod_valid |-> mod_sample.kill == (mod_sample.amp < KILL_THRESH))
    else $error("kill flag wrong");
  chk_sample_hold: assert property (mod_valid && !mod_ready |=> mod_valid && $stable(mod_sample))
    else $error("sample changed while stalled");
  chk_valid_drop: assert property ($fell(mod_valid) |-> $past(mod_ready))
    else $error("sample dropped without pop");
  chk_level_span: assert property (level_atten <= 11'h4B0)
    else $error("level out of span");
endmodule : gpp_checker

bind gaussian_pulse_pair_generator gpp_checker gpp_checker_inst (
  .clk(clk),
  .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid),
  .marker_out(marker_out),
  .mod_sample(mod_sample),
  .mod_valid(mod_valid),
  .mod_ready(mod_ready),
  .level_atten(level_atten)
);

// ---- gpp_mod_model.sv ----
/*
  Behavioural RF level modulator: pulls samples, slowly when told to stall,
  and logs pulse starts and half-amplitude widths in sample time.
  Assumes the generator's sample stream on the same clock.
*/
`timescale 1ns/1ps
module gpp_mod_model import gpp_pkg::*; (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Sample stream.
  input wire mod_sample_t mod_sample,
  input wire logic mod_valid,
  output logic mod_ready,
  // Bench control.
  input wire logic stall
);
  logic [5:0] ph;
  logic [7:0] last_amp = 8'h00;
  int pops = 0;
  int run = 0;
  int starts[$];
  int widths[$];

  // While stalling, only one cycle in eight takes a sample.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ph <= 6'h00;
      mod_ready <= 1'b0;
    end else begin
      ph <= ph + 6'h01;
      mod_ready <= !stall || (ph[5:3] == 3'h0);
    end
  end

  always @(posedge clk) begin
    if (rst_n && mod_valid && mod_ready) begin
      pops++;
      if (last_amp == AMP_ZERO && mod_sample.amp != AMP_ZERO) starts.push_back(pops);
      if (mod_sample.amp >= 8'h80) begin
        run++;
      end else if (run > 0) begin
        widths.push_back(run);
        run = 0;
      end
      last_amp = mod_sample.amp;
    end
  end
endmodule : gpp_mod_model

// ---- gaussian_pulse_pair_generator_tb_top.sv ----
/*
  Self-checking bench: register table, reset, pulse timing under stalls,
  triggered and direct modes. Assumes the modulator model beside it.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module gaussian_pulse_pair_generator_tb_top import gpp_pkg::*;;
  localparam logic [TW-1:0] P_MIN = 22'h00_0190;
  localparam logic [TW-1:0] P_MAX = 22'h00_07D0;
  typedef struct {logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} row_t;
  logic clk, rst_n, trig_in, marker_out, mod_valid, mod_ready, stall;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [10:0] level_atten;
  logic [15:0] c0;
  mod_sample_t mod_sample;
  int error_cnt = 0;
  int n_compared = 0;
  int n;
  row_t rows[14] = '{
    '{ADDR_WIDTH, 32'h0000_0064, 32'h0000_0064, RESP_OKAY},
    '{ADDR_WIDTH, 32'h0000_000A, 32'(WIDTH_MIN), RESP_OKAY},
    '{ADDR_WIDTH, 32'h0000_01F4, 32'(WIDTH_MAX), RESP_OKAY},
    '{ADDR_RISE, 32'h0000_0005, 32'(RISE_MIN), RESP_OKAY},
    '{ADDR_RISE, 32'h0000_00C8, 32'(EDGE_MAX), RESP_OKAY},
    '{ADDR_FALL, 32'h0000_000A, 32'(FALL_MIN), RESP_OKAY},
    '{ADDR_SPACE, 32'h0000_0064, 32'(SPACE_MIN), RESP_OKAY},
    '{ADDR_SPACE, 32'h0000_1388, 32'(SPACE_MAX_STEPS), RESP_OKAY},
    '{ADDR_PERIOD, 32'h0000_0001, 32'(P_MIN), RESP_OKAY},
    '{ADDR_PERIOD, 32'h0000_0BB8, 32'(P_MAX), RESP_OKAY},
    '{ADDR_LEVEL, 32'h0000_00C8, 32'(LEVEL_MAX), RESP_OKAY},
    '{ADDR_LEVEL, 32'h0000_0032, 32'h0000_0032, RESP_OKAY},
    '{8'h20, 32'h0000_0005, 32'h0000_0000, RESP_SLVERR},
    '{8'h05, 32'h0000_0005, 32'h0000_0000, RESP_SLVERR}};
  logic [7:0] ra[5] = '{ADDR_WIDTH, ADDR_RISE, ADDR_FALL, ADDR_SPACE, ADDR_CTRL};
  logic [31:0] re[5] = '{32'(WIDTH_RST), 32'(RISE_RST), 32'(FALL_RST), 32'(SPACE_RST), 32'h0};

  gaussian_pulse_pair_generator #(.PERIOD_MIN(P_MIN), .PERIOD_MAX(P_MAX))
      gaussian_pulse_pair_generator_inst (
    .clk(clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .trig_in(trig_in), .marker_out(marker_out),
    .mod_sample(mod_sample), .mod_valid(mod_valid), .mod_ready(mod_ready),
    .level_atten(level_atten));
  gpp_mod_model gpp_mod_model_inst (.clk(clk), .rst_n(rst_n), .mod_sample(mod_sample),
    .mod_valid(mod_valid), .mod_ready(mod_ready), .stall(stall));

  always #5 clk = ~clk;

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic tmo();
    error_cnt++;
    $display("[FAIL] t=%0t got %h exp %h", $time, 1'b0, 1'b1);
    close_out();
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && k < 100);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (k >= 100) tmo();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && k < 100);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (k >= 100) tmo();
  endtask : rd

  // Logic-level trigger pulse from the external source.
  task automatic trig();
    @(posedge clk);
    trig_in <= 1'b1;
    repeat (3) @(posedge clk);
    trig_in <= 1'b0;
  endtask : trig

  initial begin
    {clk, trig_in, stall, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, r);
      `CHK(r, rows[i].r)
      rd(rows[i].a, d, r);
      `CHK(d, rows[i].e)
      `CHK(r, rows[i].r)
    end
    `CHK(level_atten, 11'h032)
    $display("test registers done");
    // Reset after the register test restores the settings; the period is not read back.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], d, r);
      `CHK(d, re[i])
    end
    `CHK(level_atten, 11'h4B0)
    `CHK(mod_valid, 1'b0)
    $display("test reset done");
    wr(ADDR_WIDTH, 32'(WIDTH_MIN), r);
    wr(ADDR_RISE, 32'(RISE_MIN), r);
    wr(ADDR_FALL, 32'(FALL_MIN), r);
    wr(ADDR_SPACE, 32'(SPACE_MIN), r);
    wr(ADDR_PERIOD, 32'(P_MIN), r);
    stall <= 1'b1;
    wr(ADDR_CTRL, 32'h0000_0001, r);
    n = 0;
    do begin
      rd(ADDR_STATUS, d, r);
      n++;
    end while (d[ST_FULL] !== 1'b1 && n < 200);
    if (n >= 200) tmo();
    `CHK(d[15:8], 8'h20)
    n = 0;
    while (gpp_mod_model_inst.starts.size() < 3 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40000) tmo();
    n = gpp_mod_model_inst.starts[1] - gpp_mod_model_inst.starts[0];
    `CHK(n, SPACE_MIN * STEP_CYC)
    n = gpp_mod_model_inst.starts[2] - gpp_mod_model_inst.starts[0];
    `CHK(n, P_MIN * STEP_CYC)
    `CHK(gpp_mod_model_inst.widths[0], WIDTH_MIN * STEP_CYC)
    `CHK(gpp_mod_model_inst.widths[1], gpp_mod_model_inst.widths[0])
    stall <= 1'b0;
    wr(ADDR_CTRL, 32'h0000_0000, r);
    $display("test pulses done");
    wr(ADDR_CTRL, 32'h0000_0003, r);
    rd(ADDR_STATUS, d, r);
    c0 = d[31:16];
    trig();
    repeat (200) @(posedge clk);
    trig();
    repeat (3000) @(posedge clk);
    rd(ADDR_STATUS, d, r);
    `CHK(d[31:16], c0 + 16'h0001)
    trig();
    repeat (3000) @(posedge clk);
    rd(ADDR_STATUS, d, r);
    `CHK(d[31:16], c0 + 16'h0002)
    $display("test trigger done");
    wr(ADDR_CTRL, 32'h0000_0005, r);
    trig_in <= 1'b1;
    repeat (100) @(posedge clk);
    `CHK(gpp_mod_model_inst.last_amp, AMP_PEAK)
    trig_in <= 1'b0;
    repeat (100) @(posedge clk);
    `CHK(gpp_mod_model_inst.last_amp, AMP_ZERO)
    $display("test direct done");
    close_out();
  end
endmodule : gaussian_pulse_pair_generator_tb_top
